//--- hdl/apdu_tag_end.sv
// tag end: apdu parser, key bookkeeping, chained answers and file port
`timescale 1ns/1ps
`include "apdu_framer_map.svh"
// Operation
// RL1 - option 07h picks tamper key, read needs it
// RL2 - tamper key replaced only under root authentication
// RL3 - four device keys, leak-resilient authentication only
// RL4 - 8-bit version per key, set and queried
// RL5 - native commands only inside wrapping class
// RL6 - opcode, header, payload; return code, payload
// RL7 - only select, binary read, binary update
// RL8 - native plain fields low byte first
// RL9 - standard file fields high byte first
// RL10 - class, instruction, p1, p2, Lc, data
// RL11 - Le zero means all available data
// RL12 - one-byte Lc, at most 255 bytes
// RL13 - answer data capped at 256 bytes
// RL14 - optional data then two status bytes
// RL15 - chained frames accepted for file commands
// RL16 - answers split into frames of FSD
// RL17 - header must fit first frame else length fault
// RL18 - execute only after full reassembly
// RL19 - writes stream out before command completes
// RL20 - single-frame writes to 128 bytes atomic
// RL21 - key change needs root key 00h authentication
// RL22 - buffer overflow discards command, length fault
module apdu_tag_end
  import apdu_framer_pkg::*;
#(
  parameter logic [8:0] BUF_BYTES = 9'h080 // reassembly buffer size
) (
  input wire logic clk, // 20 MHz clock
  input wire logic reset, // synchronous, active high
  apdu_link_if.tag link, // link to the reader
  output logic [15:0] rd_addr, // file read address
  input wire logic [7:0] rd_data, // byte at rd_addr, same cycle
  input wire logic [8:0] rd_avail, // bytes available from offset
  output logic [7:0] file_no, // file addressed by file commands
  output logic [15:0] sel_fid, // last selected file identifier
  output logic wr_valid, // write byte pulse
  output logic [15:0] wr_addr, // write address
  output logic [7:0] wr_data, // write byte
  output logic wr_commit, // write command completed pulse
  output logic wr_atomic, // completed write may be committed atomically
  input wire logic [15:0] tamper_status, // tamper loop status word
  output logic auth_active // an authentication is active
);
  dev_reg_t cur;
  dev_reg_t next_cur;

  // parse, execute and answer in one next-state function
  always_comb begin
    logic [8:0] di;
    logic push;
    logic fin;
    logic [7:0] pbyte;
    logic [7:0] lc;
    logic [7:0] le;
    logic is_wr;
    logic root;
    logic [8:0] req;
    rsp_entry_t pe;
    di = cur.idx - `HDR_BYTES;
    push = 1'b0;
    fin = 1'b0;
    pbyte = 8'h00;
    lc = (cur.idx > `HDR_BYTES) ? cur.b4 : 8'h00; // RL10
    le = (cur.idx == `HDR_BYTES) ? cur.b4 : cur.le;
    is_wr = (cur.cla == `CLA_WRAP && cur.ins == `OP_FILE_WRITE) ||
            (cur.cla == `CLA_ISO && cur.ins == `INS_UPDATE_BIN);
    root = cur.auth_active && cur.auth_key == `ROOT_KEY;
    req = 9'h000;
    pe = '0;
    next_cur = cur;
    next_cur.wr_valid = 1'b0;
    next_cur.wr_commit = 1'b0;
    // drain side of the two-entry answer buffer
    if (cur.cnt != 2'h0 && link.rsp_ready) begin
      next_cur.q0 = cur.q1;
      next_cur.cnt = cur.cnt - 2'h1;
    end
    case (cur.st)
      DEV_RX: begin
        if (link.cmd_valid && cur.cmd_ready) begin
          next_cur.idx = cur.idx + 9'h001;
          case (cur.idx)
            9'h000: next_cur.cla = link.cmd_data;
            9'h001: next_cur.ins = link.cmd_data;
            9'h002: next_cur.p1 = link.cmd_data;
            9'h003: begin
              next_cur.p2 = link.cmd_data;
              next_cur.off = {9'h000, cur.p1[6:0], link.cmd_data}; // RL9
            end
            9'h004: next_cur.b4 = link.cmd_data; // RL12
            default: begin
              if (di < {1'b0, cur.b4}) begin
                case (di)
                  9'h000: next_cur.f0 = link.cmd_data;
                  9'h001: begin
                    next_cur.f1 = link.cmd_data;
                    next_cur.off[7:0] = link.cmd_data; // RL8
                  end
                  9'h002: begin
                    next_cur.f2 = link.cmd_data;
                    next_cur.off[15:8] = link.cmd_data;
                  end
                  9'h003: next_cur.off[23:16] = link.cmd_data;
                  9'h004: next_cur.len[7:0] = link.cmd_data;
                  9'h005: next_cur.len[15:8] = link.cmd_data;
                  9'h006: next_cur.len[23:16] = link.cmd_data;
                  `KEYREP_VER_POS: next_cur.kver = link.cmd_data;
                  default: next_cur.kver = cur.kver;
                endcase
                // after field decode, so native offset bytes never move a standard-file write
                if (is_wr && (cur.cla == `CLA_ISO || di >= `NATIVE_WR_HDR)) begin
                  // stream write data out before the command is complete
                  next_cur.wr_valid = 1'b1; // RL19
                  next_cur.wr_addr = cur.off[15:0];
                  next_cur.wr_data = link.cmd_data;
                  next_cur.off = cur.off + 24'h000001;
                end else if (!is_wr && cur.idx >= BUF_BYTES) begin
                  next_cur.ovf = 1'b1; // RL22
                end
              end else if (di == {1'b0, cur.b4} && !cur.le_seen) begin
                next_cur.le = link.cmd_data;
                next_cur.le_seen = 1'b1;
              end else begin
                next_cur.bad_len = 1'b1;
              end
            end
          endcase
          if (link.cmd_last && link.cmd_chain) begin
            next_cur.chained = 1'b1; // RL15
            if (cur.idx < 9'h003) begin
              next_cur.hdr_fault = 1'b1; // RL17
            end
          end
          if (link.cmd_last && !link.cmd_chain) begin
            next_cur.st = DEV_EXEC; // RL18
          end
        end
      end
      DEV_EXEC: begin
        next_cur.st = DEV_EMIT;
        next_cur.rlen = 2'h0;
        next_cur.sw1 = `SW1_NATIVE;
        next_cur.sw2 = `RC_OK;
        if (cur.cla == `CLA_WRAP) begin
          if (cur.hdr_fault || cur.ovf || cur.bad_len || cur.idx < 9'h004) begin
            next_cur.sw2 = `RC_LENGTH; // RL22
          end else begin
            // native opcode travels as the instruction byte
            case (cur.ins) // RL6
              `OP_KEY_REPLACE: begin
                if (!root) begin
                  next_cur.sw2 = `RC_AUTH; // RL21
                end else if (cur.f0 >= `APP_KEYS) begin
                  next_cur.sw2 = `RC_NO_KEY;
                end else if (lc < `KEYREP_MIN_LC) begin
                  next_cur.sw2 = `RC_LENGTH;
                end else begin
                  // tamper key is an application key, so same path
                  next_cur.ver[cur.f0[2:0]] = cur.kver; // RL2 RL4
                end
              end
              `OP_VERSION: begin
                next_cur.rlen = 2'h1; // RL4
                if (cur.f0 < `APP_KEYS) begin
                  next_cur.rdat = {8'h00, cur.ver[cur.f0[2:0]]};
                end else if (cur.f0[`KEYSEL_DEV_BIT] && cur.f0[6:0] >= `GEN_FIRST &&
                             cur.f0[6:0] <= `GEN_LAST) begin
                  next_cur.rdat = {8'h00, cur.gver[cur.f0[1:0] - 2'h1]};
                end else begin
                  next_cur.rlen = 2'h0;
                  next_cur.sw2 = `RC_NO_KEY;
                end
              end
              `OP_CONFIG: begin
                if (cur.f0 != `OPT_TAMPER) begin
                  next_cur.sw2 = `RC_PARAM;
                end else if (!root) begin
                  next_cur.sw2 = `RC_AUTH;
                end else if (cur.f1[0] && cur.f2 >= `APP_KEYS) begin
                  next_cur.sw2 = `RC_NO_KEY;
                end else begin
                  next_cur.tamper_en = cur.f1[0]; // RL1
                  next_cur.tamper_key = cur.f2[2:0];
                end
              end
              `OP_TAMPER_READ: begin
                if (cur.tamper_en && !(cur.auth_active && cur.auth_key == cur.tamper_key)) begin
                  next_cur.sw2 = `RC_AUTH; // RL1
                end else begin
                  next_cur.rdat = tamper_status; // RL8
                  next_cur.rlen = 2'h2;
                end
              end
              `OP_AUTH_FIRST, `OP_AUTH_FOLLOWUP: begin
                if (cur.f0[`KEYSEL_DEV_BIT]) begin
                  // device keys only through the leak-resilient variants
                  if (cur.f0[6:0] < `GEN_FIRST || cur.f0[6:0] > `GEN_LAST) begin
                    next_cur.sw2 = `RC_NO_KEY;
                  end else if (cur.ins == `OP_AUTH_FIRST && !cur.f1[`LRP_CAP_BIT]) begin
                    next_cur.sw2 = `RC_NO_KEY; // RL3
                  end
                end else if (cur.f0 >= `APP_KEYS) begin
                  next_cur.sw2 = `RC_NO_KEY;
                end else if (cur.ins == `OP_AUTH_FOLLOWUP && !cur.auth_active) begin
                  next_cur.sw2 = `RC_AUTH;
                end else begin
                  next_cur.auth_active = 1'b1;
                  next_cur.auth_key = cur.f0[2:0];
                end
              end
              `OP_FILE_READ: begin
                req = (cur.len == 24'h0 || cur.len > 24'h000100) ? `RSP_MAX : cur.len[8:0];
                next_cur.st = DEV_RD_A;
              end
              `OP_FILE_WRITE: begin
                next_cur.wr_commit = 1'b1;
              end
              default: next_cur.sw2 = `RC_ILLEGAL;
            endcase
          end
        end else if (cur.cla == `CLA_ISO) begin
          {next_cur.sw1, next_cur.sw2} = `SW_ISO_OK;
          if (cur.hdr_fault || cur.ovf || cur.bad_len || cur.idx < 9'h004) begin
            {next_cur.sw1, next_cur.sw2} = `SW_ISO_LENGTH;
          end else begin
            case (cur.ins) // RL7
              `INS_SELECT: next_cur.sel_fid = {cur.f0, cur.f1}; // RL9
              `INS_READ_BIN: begin
                req = (le == 8'h00) ? `RSP_MAX : {1'b0, le}; // RL11
                next_cur.st = DEV_RD_A;
              end
              `INS_UPDATE_BIN: next_cur.wr_commit = 1'b1;
              default: {next_cur.sw1, next_cur.sw2} = `SW_ISO_INS;
            endcase
          end
        end else begin
          {next_cur.sw1, next_cur.sw2} = `SW_ISO_CLA; // RL5
        end
        // answer never exceeds request, availability or 256 bytes
        next_cur.rem = (rd_avail < req) ? rd_avail : req; // RL13
        if (next_cur.st == DEV_RD_A && next_cur.rem == 9'h000) begin
          next_cur.st = DEV_SW1; // RL14
        end
        next_cur.file_no = (cur.cla == `CLA_WRAP) ? cur.f0 : cur.file_no;
        next_cur.wr_atomic = !cur.chained && lc <= `WR_ATOMIC_MAX; // RL20
      end
      DEV_RD_A: begin
        next_cur.rd_addr = cur.off[15:0];
        next_cur.st = DEV_RD_D;
      end
      DEV_RD_D: begin
        if (cur.cnt != 2'h2) begin
          push = 1'b1;
          pbyte = rd_data;
          next_cur.off = cur.off + 24'h000001;
          next_cur.rem = cur.rem - 9'h001;
          next_cur.st = (cur.rem == 9'h001) ? DEV_SW1 : DEV_RD_A;
        end
      end
      DEV_EMIT: begin
        if (cur.rlen == 2'h0) begin
          next_cur.st = DEV_SW1;
        end else if (cur.cnt != 2'h2) begin
          push = 1'b1;
          pbyte = cur.rdat[7:0];
          next_cur.rdat = {8'h00, cur.rdat[15:8]};
          next_cur.rlen = cur.rlen - 2'h1;
        end
      end
      DEV_SW1: begin
        if (cur.cnt != 2'h2) begin
          push = 1'b1;
          pbyte = cur.sw1; // RL14
          next_cur.st = DEV_SW2;
        end
      end
      DEV_SW2: begin
        if (cur.cnt != 2'h2) begin
          push = 1'b1;
          fin = 1'b1;
          pbyte = cur.sw2;
          next_cur.st = DEV_RX;
          next_cur.idx = 9'h000;
          next_cur.le_seen = 1'b0;
          next_cur.bad_len = 1'b0;
          next_cur.ovf = 1'b0;
          next_cur.hdr_fault = 1'b0;
          next_cur.chained = 1'b0;
        end
      end
      default: next_cur.st = DEV_RX;
    endcase
    // fill side: cut a frame at FSD bytes, chain unless status is done
    if (push) begin
      pe.data = pbyte;
      pe.last = fin || (cur.ocnt == link.fsd - 8'h01); // RL16
      pe.chain = pe.last && !fin;
      next_cur.ocnt = pe.last ? 8'h00 : cur.ocnt + 8'h01;
      if (next_cur.cnt == 2'h0) begin
        next_cur.q0 = pe;
      end else begin
        next_cur.q1 = pe;
      end
      next_cur.cnt = next_cur.cnt + 2'h1;
    end
    next_cur.rsp_valid = next_cur.cnt != 2'h0;
    next_cur.cmd_ready = next_cur.st == DEV_RX;
  end

  // state register; key versions start at their reset value
  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
      cur.ver <= {5{`KEY_VER_RESET}};
      cur.gver <= {4{`KEY_VER_RESET}};
    end else begin
      cur <= next_cur;
    end
  end

  assign link.cmd_ready = cur.cmd_ready;
  assign link.rsp_valid = cur.rsp_valid;
  assign link.rsp_data = cur.q0.data;
  assign link.rsp_last = cur.q0.last;
  assign link.rsp_chain = cur.q0.chain;
  assign rd_addr = cur.rd_addr;
  assign file_no = cur.file_no;
  assign sel_fid = cur.sel_fid;
  assign wr_valid = cur.wr_valid;
  assign wr_addr = cur.wr_addr;
  assign wr_data = cur.wr_data;
  assign wr_commit = cur.wr_commit;
  assign wr_atomic = cur.wr_atomic;
  assign auth_active = cur.auth_active;
endmodule

//--- hdl/apdu_framer_map.svh
// constants: codes, field positions, limits and reset values of the apdu framer
`ifndef APDU_FRAMER_MAP_SVH
`define APDU_FRAMER_MAP_SVH

`define CLA_WRAP 8'h90
`define CLA_ISO 8'h00
`define INS_SELECT 8'hA4
`define INS_READ_BIN 8'hB0
`define INS_UPDATE_BIN 8'hD6

`define OP_KEY_REPLACE 8'hC4
`define OP_VERSION 8'h64
`define OP_CONFIG 8'h5C
`define OP_TAMPER_READ 8'hF7
`define OP_AUTH_FIRST 8'h71
`define OP_AUTH_FOLLOWUP 8'h77
`define OP_FILE_READ 8'hAD
`define OP_FILE_WRITE 8'h8D

`define SW1_NATIVE 8'h91
`define RC_OK 8'h00
`define RC_LENGTH 8'h7E
`define RC_AUTH 8'hAE
`define RC_NO_KEY 8'h40
`define RC_ILLEGAL 8'h1C
`define RC_PARAM 8'h9E
`define SW_ISO_OK 16'h9000
`define SW_ISO_LENGTH 16'h6700
`define SW_ISO_INS 16'h6D00
`define SW_ISO_CLA 16'h6E00

`define OPT_TAMPER 8'h07
`define ROOT_KEY 3'h0
`define APP_KEYS 8'h05
`define GEN_FIRST 7'h01
`define GEN_LAST 7'h04
`define KEYSEL_DEV_BIT 7
`define LRP_CAP_BIT 1
`define KEY_VER_RESET 8'h00

`define HDR_BYTES 9'h005
`define NATIVE_WR_HDR 9'h007
`define KEYREP_VER_POS 9'h011
`define KEYREP_MIN_LC 8'h12
`define WR_ATOMIC_MAX 8'h80
`define RSP_MAX 9'h100
`define APDU_MAX 9'h104

`endif

//--- hdl/apdu_framer_pkg.sv
// types shared by the two ends of the apdu link
package apdu_framer_pkg;

  typedef enum logic [2:0] {
    DEV_RX, DEV_EXEC, DEV_RD_A, DEV_RD_D, DEV_EMIT, DEV_SW1, DEV_SW2
  } dev_state_t;

  typedef enum logic [0:0] {HOST_PASS, HOST_LE} host_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic chain;
  } rsp_entry_t;

  typedef struct packed {
    dev_state_t st;
    logic [8:0] idx;
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] b4;
    logic [7:0] le;
    logic le_seen;
    logic bad_len;
    logic ovf;
    logic hdr_fault;
    logic chained;
    logic [7:0] f0;
    logic [7:0] f1;
    logic [7:0] f2;
    logic [7:0] kver;
    logic [23:0] len;
    logic [23:0] off;
    logic [15:0] sel_fid;
    logic [7:0] file_no;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic [15:0] rdat;
    logic [1:0] rlen;
    logic [8:0] rem;
    logic [7:0] ocnt;
    logic auth_active;
    logic [2:0] auth_key;
    logic [4:0][7:0] ver;
    logic [3:0][7:0] gver;
    logic tamper_en;
    logic [2:0] tamper_key;
    logic wr_valid;
    logic wr_commit;
    logic wr_atomic;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
    logic [15:0] rd_addr;
    logic cmd_ready;
    logic rsp_valid;
    logic [1:0] cnt;
    rsp_entry_t q0;
    rsp_entry_t q1;
  } dev_reg_t;

  typedef struct packed {
    host_state_t st;
    logic [8:0] cnt;
    logic [7:0] frm;
    logic wrapped;
    logic [7:0] le;
    logic req_ready;
    logic cmd_valid;
    logic [7:0] cmd_data;
    logic cmd_last;
    logic cmd_chain;
    logic [7:0] fsd;
    logic rsp_ready;
    logic resp_valid;
    logic [7:0] resp_byte;
    logic resp_end;
  } host_reg_t;

endpackage

//--- hdl/apdu_link_if.sv
// byte-stream link between reader and tag, block frames marked by last and chain
`timescale 1ns/1ps
interface apdu_link_if;
  logic cmd_valid;
  logic [7:0] cmd_data;
  logic cmd_last;
  logic cmd_chain;
  logic cmd_ready;
  logic [7:0] fsd;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_last;
  logic rsp_chain;
  logic rsp_ready;

  modport reader (
    output cmd_valid, cmd_data, cmd_last, cmd_chain, fsd, rsp_ready,
    input cmd_ready, rsp_valid, rsp_data, rsp_last, rsp_chain
  );
  modport tag (
    input cmd_valid, cmd_data, cmd_last, cmd_chain, fsd, rsp_ready,
    output cmd_ready, rsp_valid, rsp_data, rsp_last, rsp_chain
  );
endinterface

//--- hdl/apdu_reader_end.sv
// reader end: frames user apdus into chained blocks and reassembles answers
`timescale 1ns/1ps
`include "apdu_framer_map.svh"
module apdu_reader_end
  import apdu_framer_pkg::*;
#(
  parameter logic [7:0] FSC = 8'h40, // tag frame size from its answer to select
  parameter logic [7:0] FSD = 8'h40  // own frame size, announced to the tag
) (
  input wire logic clk, // 20 MHz clock
  input wire logic reset, // synchronous, active high
  apdu_link_if.reader link, // link to the tag
  input wire logic req_valid, // user apdu byte present
  input wire logic [7:0] req_byte, // apdu byte, Le excluded
  input wire logic req_last, // last byte of the apdu
  input wire logic [7:0] req_le, // Le for standard file commands
  output logic req_ready, // byte taken when high with req_valid
  output logic resp_valid, // answer byte present
  output logic [7:0] resp_byte, // answer byte
  output logic resp_end, // byte is the last status byte
  input wire logic resp_ready // user takes the answer byte
);
  host_reg_t cur;
  host_reg_t next_cur;

  // next state of the whole reader end
  always_comb begin
    logic fin;
    logic slot;
    fin = 1'b0;
    slot = !cur.cmd_valid || link.cmd_ready;
    next_cur = cur;
    next_cur.fsd = FSD; // RL16
    if (cur.cmd_valid && link.cmd_ready) begin
      next_cur.cmd_valid = 1'b0;
    end
    if (slot && cur.st == HOST_LE) begin
      // wrapped commands always close with Le zero
      next_cur.cmd_data = cur.wrapped ? 8'h00 : cur.le; // RL11
      fin = 1'b1;
      next_cur.cmd_valid = 1'b1;
      next_cur.st = HOST_PASS;
    end else if (cur.req_ready && req_valid) begin
      if (cur.cnt == 9'h000) begin
        next_cur.wrapped = req_byte == `CLA_WRAP; // RL5
      end
      if (req_last) begin
        next_cur.st = HOST_LE;
        next_cur.le = req_le;
      end
      // bytes past header plus 255 data bytes are dropped
      if (cur.cnt < `APDU_MAX) begin // RL12
        next_cur.cmd_data = req_byte; // RL10
        next_cur.cmd_valid = 1'b1;
        next_cur.cnt = cur.cnt + 9'h001;
      end
    end
    // block framing: full frame of FSC bytes or end of apdu
    if (next_cur.cmd_valid && !cur.cmd_valid || next_cur.cmd_valid && link.cmd_ready) begin
      next_cur.cmd_last = fin || (cur.frm == FSC - 8'h01); // RL17
      next_cur.cmd_chain = !fin && (cur.frm == FSC - 8'h01);
      next_cur.frm = next_cur.cmd_last ? 8'h00 : cur.frm + 8'h01;
    end
    if (fin) begin
      next_cur.cnt = 9'h000;
    end
    next_cur.req_ready = next_cur.st == HOST_PASS && !next_cur.cmd_valid && !(req_last
      && cur.req_ready && req_valid);
    // answer side holding register
    if (cur.resp_valid && resp_ready) begin
      next_cur.resp_valid = 1'b0;
    end
    if (cur.rsp_ready && link.rsp_valid) begin
      next_cur.resp_valid = 1'b1;
      next_cur.resp_byte = link.rsp_data; // RL6
      next_cur.resp_end = link.rsp_last && !link.rsp_chain;
    end
    next_cur.rsp_ready = !next_cur.resp_valid;
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign link.cmd_valid = cur.cmd_valid;
  assign link.cmd_data = cur.cmd_data;
  assign link.cmd_last = cur.cmd_last;
  assign link.cmd_chain = cur.cmd_chain;
  assign link.fsd = cur.fsd;
  assign link.rsp_ready = cur.rsp_ready;
  assign req_ready = cur.req_ready;
  assign resp_valid = cur.resp_valid;
  assign resp_byte = cur.resp_byte;
  assign resp_end = cur.resp_end;
endmodule

//--- verification/apdu_link_checker.sv
// assertions on the reader to tag link
`timescale 1ns/1ps
module apdu_link_checker (
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic cmd_valid, // cmd byte
  input wire logic [7:0] cmd_data, // cmd data
  input wire logic cmd_last, // frame end
  input wire logic cmd_chain, // more frames
  input wire logic cmd_ready, // tag takes
  input wire logic [7:0] fsd, // frame size
  input wire logic rsp_valid, // rsp byte
  input wire logic [7:0] rsp_data, // rsp data
  input wire logic rsp_last, // frame end
  input wire logic rsp_chain, // more frames
  input wire logic rsp_ready // reader takes
);
  logic [8:0] fcnt, tot;
  wire hs = rsp_valid & rsp_ready;
  wire fin = cmd_valid & cmd_ready & cmd_last & !cmd_chain;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // counts only, so no answer data is stored
  always_ff @(posedge clk) begin
    if (reset) begin
      fcnt <= 9'h000;
      tot <= 9'h000;
    end else if (hs) begin
      fcnt <= rsp_last ? 9'h000 : fcnt + 9'h001;
      tot <= (rsp_last && !rsp_chain) ? 9'h000 : tot + 9'h001;
    end
  end
  cmd_refused_a: assert property (fin |=> !cmd_ready) else $error("busy take");
  rsp_soon_a: assert property (fin |-> ##[3:4] rsp_valid) else $error("late");
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("rsp dropped");
  frame_size_a: assert property (hs |-> fcnt < {1'b0, fsd}) else $error("frame long");
  frame_cut_a: assert property (hs && rsp_chain |-> rsp_last && fcnt + 9'h001 == {1'b0, fsd})
    else $error("frame cut");
  answer_cap_a: assert property (hs |-> tot < 9'h102) else $error("answer long");
  status_pair_a: assert property (hs && rsp_last && !rsp_chain |-> tot != 9'h000)
    else $error("status short");
  cmd_chain_a: assert property (cmd_valid && cmd_chain |-> cmd_last) else $error("chain");
endmodule

//--- verification/test_apdu_command_framer.sv
// bench: reader and tag ends joined over the link
`timescale 1ns/1ps
`include "apdu_framer_map.svh"
module test_apdu_command_framer;
  logic clk = 0;
  logic reset = 1;
  logic req_valid = 0, req_last = 0, resp_ready = 0;
  logic [7:0] req_byte = 0, req_le = 0, rd_data, resp_byte, file_no, wr_data;
  logic req_ready, resp_valid, resp_end, wr_valid, wr_commit, wr_atomic, auth_active;
  logic [8:0] rd_avail = 0;
  logic [15:0] tamper_status = 0, rd_addr, sel_fid, wr_addr;
  logic [15:0] eq[$], wq[$];
  int miscompares = 0, n_checks = 0, tn = 0;
  apdu_link_if lk();
  apdu_reader_end #(.FSD(8'h06)) apdu_reader_end_inst (.clk(clk), .reset(reset), .link(lk),
    .req_valid(req_valid), .req_byte(req_byte), .req_last(req_last), .req_le(req_le),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_byte(resp_byte),
    .resp_end(resp_end), .resp_ready(resp_ready));
  apdu_tag_end apdu_tag_end_inst (.clk(clk), .reset(reset), .link(lk), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_avail(rd_avail), .file_no(file_no), .sel_fid(sel_fid),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_commit(wr_commit),
    .wr_atomic(wr_atomic), .tamper_status(tamper_status), .auth_active(auth_active));
  apdu_link_checker apdu_link_checker_inst (.clk(clk), .reset(reset), .cmd_valid(lk.cmd_valid),
    .cmd_data(lk.cmd_data), .cmd_last(lk.cmd_last), .cmd_chain(lk.cmd_chain),
    .cmd_ready(lk.cmd_ready), .fsd(lk.fsd), .rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data),
    .rsp_last(lk.rsp_last), .rsp_chain(lk.rsp_chain), .rsp_ready(lk.rsp_ready));
  // file model: data tied to address so offsets show
  always_comb rd_data = rd_addr[7:0] ^ 8'h5A;
  initial forever #25 clk = ~clk;
  // random stalls, the two-entry buffer must lose nothing
  always @(negedge clk) resp_ready <= ($urandom_range(3) != 0);
  function automatic logic [15:0] pop(ref logic [15:0] q[$]);
    return q.size() ? q.pop_front() : 16'hFFFF;
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    n_checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // oldest note first
  always @(posedge clk) begin
    if (resp_valid === 1'b1 && resp_ready === 1'b1)
      check({7'h00, resp_end, resp_byte}, pop(eq), "resp");
    if (wr_valid === 1'b1)
      check({wr_addr[7:0], wr_data}, pop(wq), "write");
    if (wr_commit === 1'b1)
      check(wr_atomic, 1'b1, "atomic");
  end
  task run(input logic [7:0] b[$], input logic [7:0] le, input logic [15:0] r[$]);
    foreach (r[i]) eq.push_back(r[i] | ((i == r.size() - 1) ? 16'h0100 : 16'h0000));
    foreach (b[i]) begin
      @(negedge clk);
      req_valid = 1'b1;
      req_byte = b[i];
      req_last = (i == b.size() - 1);
      req_le = le;
      @(posedge clk);
      while (req_ready !== 1'b1) @(posedge clk);
    end
    @(negedge clk);
    req_valid = 1'b0;
    while (eq.size() != 0) @(posedge clk);
    tn++;
    $display("test %0d done", tn);
  endtask
  task native(input logic [7:0] op, input logic [7:0] f0, input logic [15:0] r[$]);
    run('{`CLA_WRAP, op, 8'h00, 8'h00, 8'h02, f0, 8'h02}, 8'h00, r);
  endtask
  task keyrep(input logic [7:0] k, input logic [7:0] v, input logic [7:0] rc);
    logic [7:0] b[$];
    b = '{`CLA_WRAP, `OP_KEY_REPLACE, 8'h00, 8'h00, `KEYREP_MIN_LC, k};
    repeat (16) b.push_back(8'h00);
    b.push_back(v);
    run(b, 8'h00, '{`SW1_NATIVE, rc});
  endtask
  initial begin
    logic [15:0] r[$];
    logic [7:0] v;
    int n;
    v = 8'($urandom(41));
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    native(`OP_VERSION, 8'h00, '{`KEY_VER_RESET, `SW1_NATIVE, `RC_OK});
    v = 8'($urandom);
    keyrep(8'h01, v, `RC_AUTH);
    native(`OP_AUTH_FIRST, 8'h01, '{`SW1_NATIVE, `RC_OK});
    check(auth_active, 1'b1, "auth");
    keyrep(8'h01, v, `RC_AUTH);
    native(`OP_AUTH_FIRST, `ROOT_KEY, '{`SW1_NATIVE, `RC_OK});
    keyrep(8'h01, v, `RC_OK);
    keyrep(`APP_KEYS, v, `RC_NO_KEY);
    native(`OP_VERSION, 8'h01, '{v, `SW1_NATIVE, `RC_OK});
    native(`OP_AUTH_FIRST, 8'h84, '{`SW1_NATIVE, `RC_OK});
    native(`OP_VERSION, 8'h84, '{`KEY_VER_RESET, `SW1_NATIVE, `RC_OK});
    @(negedge clk);
    tamper_status = 16'($urandom);
    r = '{tamper_status[7:0], tamper_status[15:8], `SW1_NATIVE, `RC_OK};
    run('{`CLA_WRAP, `OP_TAMPER_READ, 8'h00, 8'h00}, 8'h00, r);
    run('{8'h80, `INS_READ_BIN, 8'h00, 8'h00}, 8'h00, '{`SW_ISO_CLA >> 8, 8'h00});
    run('{`CLA_ISO, `OP_VERSION, 8'h00, 8'h00}, 8'h00, '{`SW_ISO_INS >> 8, 8'h00});
    run('{`CLA_ISO, `INS_SELECT, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h04}, 8'h00,
      '{`SW_ISO_OK >> 8, 8'h00});
    check(sel_fid, 16'hE104, "select");
    // Le 00 returns all, Le 04 caps, long answers framed by fsd
    for (int k = 0; k < 2; k++) begin
      n = $urandom_range(40, 5);
      @(negedge clk);
      rd_avail = n[8:0];
      r = {};
      for (int i = 0; i < (k ? 4 : n); i++) r.push_back((8'h20 + i[7:0]) ^ 8'h5A);
      r.push_back(`SW_ISO_OK >> 8);
      r.push_back(8'h00);
      run('{`CLA_ISO, `INS_READ_BIN, 8'h01, 8'h20}, k ? 8'h04 : 8'h00, r);
    end
    wq = '{{8'h10, v}, {8'h11, ~v}, {8'h12, 8'h00}};
    r = '{`SW_ISO_OK >> 8, 8'h00};
    run('{`CLA_ISO, `INS_UPDATE_BIN, 8'h00, 8'h10, 8'h03, v, ~v, 8'h00}, 8'h00, r);
    check(16'(wq.size()), 16'h0000, "writes");
    results();
  end
  initial begin
    #2000000;
    $display("watchdog expired");
    miscompares++;
    results();
  end
endmodule
